// [fec_flash_ctrl.sv]
// flash array with control register, arming sequencer, protection and erase sweep
//
// Overview of operation
// - erased bits read one, programmed bits zero
// - byte array, 64-byte page erase clears page
// - 8192 bytes, byte program, page erase
// - control FE08, protect FF7E, vectors FFDC-FFFF
// - high voltage needs select and completed arming
// - whole-array select readable, erase covers array
// - erase and program selects never both one
// - pages start on 64-byte boundaries, erasable alone
// - whole-array erase refused unless protect is FF
// - protected address blocks setting high voltage
// - protect byte gives start address bits 13:6
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module fec_flash_ctrl (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    // register and array bus
    input  wire logic [fec_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [fec_pkg::DATA_W-1:0]  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [fec_pkg::DATA_W-1:0]  rdata_o,
    // status towards the analogue side
    output logic                             charge_pump_on_o,
    output logic                             erase_busy_o
);
    import fec_pkg::*;

    // ----------------------------------------------------------------
    // storage and state
    // ----------------------------------------------------------------
    // the array leaves the factory erased; reset never touches it
    logic [7:0]           mem [0:ARRAY_WORDS-1] = '{default: ERASED_BYTE};
    logic                 hv_reg,     hv_next;
    logic                 mass_reg,   mass_next;
    logic                 erase_reg,  erase_next;
    logic                 pgm_reg,    pgm_next;
    fec_arm_e             arm_reg,    arm_next;
    logic [12:0]          lat_reg,    lat_next;
    logic                 sweep_reg,  sweep_next;
    logic [12:0]          sidx_reg,   sidx_next;
    logic [12:0]          sleft_reg,  sleft_next;
    logic [7:0]           rdata_reg,  rdata_next;

    // ----------------------------------------------------------------
    // address decode and protection
    // ----------------------------------------------------------------
    logic                 is_ctrl;
    logic                 is_array;
    logic                 is_prot;
    logic [12:0]          idx;
    logic [7:0]           prot_val;
    logic [15:0]          prot_start;
    logic                 lat_protected;
    logic                 addr_protected;
    logic                 mass_refused;
    logic                 hv_allowed;
    logic                 prog_wr;
    logic [7:0]           cell_val;

    // control register wins over the array byte it overlays
    assign is_ctrl    = (addr_i == CTRL_ADDR);
    assign is_array   = (addr_i[15:13] == ARRAY_TOP) && !is_ctrl;
    assign is_prot    = (addr_i == PROT_ADDR);
    assign idx        = addr_i[12:0];
    assign cell_val   = mem[idx];
    assign prot_val   = mem[PROT_IDX];
    assign prot_start = {PROT_HI, prot_val, PROT_LO};
    // all-ones means nothing protected; otherwise start up to the top
    assign lat_protected  = (prot_val != PROT_NONE)
                            && ({ARRAY_TOP, lat_reg} >= prot_start);
    assign addr_protected = (prot_val != PROT_NONE)
                            && (addr_i >= prot_start);
    assign mass_refused   = mass_reg && erase_reg
                            && (prot_val != PROT_NONE);
    // only an armed sequence on an open region may raise the pump
    assign hv_allowed = (erase_reg || pgm_reg) && (arm_reg == ARM_ARMED)
                        && !lat_protected && !mass_refused;
    assign prog_wr    = wr_i && is_array && pgm_reg && hv_reg && !addr_protected;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    // selects follow the write, high voltage only rises when allowed
    always_comb begin
        hv_next    = hv_reg;
        mass_next  = mass_reg;
        erase_next = erase_reg;
        pgm_next   = pgm_reg;
        if (wr_i && is_ctrl) begin
            mass_next = wdata_i[MASS_BIT];
            // a write asking for both keeps the old pair untouched
            if (!(wdata_i[ERASE_BIT] && wdata_i[PGM_BIT])) begin
                erase_next = wdata_i[ERASE_BIT];
                pgm_next   = wdata_i[PGM_BIT];
            end
            if (!wdata_i[HV_BIT]) begin
                hv_next = 1'b0;
            end else if (!hv_reg) begin
                hv_next = hv_allowed;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hv_reg    <= CTRL_RESET[HV_BIT];
            mass_reg  <= CTRL_RESET[MASS_BIT];
            erase_reg <= CTRL_RESET[ERASE_BIT];
            pgm_reg   <= CTRL_RESET[PGM_BIT];
        end else begin
            hv_reg    <= hv_next;
            mass_reg  <= mass_next;
            erase_reg <= erase_next;
            pgm_reg   <= pgm_next;
        end
    end

    // ----------------------------------------------------------------
    // arming sequencer
    // ----------------------------------------------------------------
    // other bus traffic between steps is ignored, not an abort
    always_comb begin
        arm_next = arm_reg;
        lat_next = lat_reg;
        unique case (arm_reg)
            ARM_IDLE: begin
                if (erase_reg || pgm_reg) begin
                    arm_next = ARM_SEL;
                end
            end
            ARM_SEL: begin
                if (rd_i && is_prot) begin
                    arm_next = ARM_PROT;
                end
            end
            ARM_PROT: begin
                if (wr_i && is_array) begin
                    arm_next = ARM_ARMED;
                    lat_next = idx;
                end
            end
            ARM_ARMED: begin
                if (hv_next) begin
                    arm_next = ARM_HIGH;
                end
            end
            ARM_HIGH: begin
                if (!hv_reg) begin
                    arm_next = ARM_IDLE;
                end
            end
        endcase
        // dropping both selects with the pump off restarts the sequence
        if (!erase_reg && !pgm_reg && !hv_reg) begin
            arm_next = ARM_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            arm_reg <= ARM_IDLE;
            lat_reg <= SWEEP_ZERO;
        end else begin
            arm_reg <= arm_next;
            lat_reg <= lat_next;
        end
    end

    // ----------------------------------------------------------------
    // erase sweep
    // ----------------------------------------------------------------
    // one byte per cycle keeps the array single-ported; pump loss aborts
    always_comb begin
        sweep_next = sweep_reg;
        sidx_next  = sidx_reg;
        sleft_next = sleft_reg;
        if (hv_next && !hv_reg && erase_reg) begin
            sweep_next = 1'b1;
            if (mass_reg) begin
                sidx_next  = SWEEP_ZERO;
                sleft_next = MASS_LAST;
            end else begin
                sidx_next  = {lat_reg[12:PAGE_AW], PROT_LO};
                sleft_next = PAGE_LAST;
            end
        end else if (sweep_reg) begin
            sidx_next  = sidx_reg + SWEEP_ONE;
            sleft_next = sleft_reg - SWEEP_ONE;
            if (sleft_reg == SWEEP_ZERO) begin
                sweep_next = 1'b0;
            end
        end
        if (!hv_next) begin
            sweep_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sweep_reg <= 1'b0;
            sidx_reg  <= SWEEP_ZERO;
            sleft_reg <= SWEEP_ZERO;
        end else begin
            sweep_reg <= sweep_next;
            sidx_reg  <= sidx_next;
            sleft_reg <= sleft_next;
        end
    end

    // ----------------------------------------------------------------
    // array writes
    // ----------------------------------------------------------------
    // programming can only pull bits to zero; erase restores ones
    always_ff @(posedge clk_i) begin
        if (sweep_reg) begin
            mem[sidx_reg] <= ERASED_BYTE;
        end else if (prog_wr) begin
            mem[idx] <= mem[idx] & wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // data stands for exactly one cycle after the strobe
    always_comb begin
        rdata_next = RDATA_IDLE;
        if (rd_i && is_ctrl) begin
            rdata_next = {CTRL_PAD, hv_reg, mass_reg, erase_reg, pgm_reg};
        end else if (rd_i && is_array) begin
            rdata_next = cell_val;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= RDATA_IDLE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o          = rdata_reg;
    assign charge_pump_on_o = hv_reg;
    assign erase_busy_o     = sweep_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    select_interlock_a: assert property (!(erase_reg && pgm_reg))
        else $error("erase and program selects both set");
    hv_arming_a: assert property ($rose(hv_reg) |->
        $past(arm_reg) == ARM_ARMED && ($past(erase_reg) || $past(pgm_reg)))
        else $error("high voltage rose without completed arming");
    arm_prot_read_a: assert property (
        (arm_reg == ARM_SEL) ##1 (arm_reg == ARM_PROT) |-> $past(rd_i) && $past(is_prot))
        else $error("protect step taken without protect read");
    mass_refuse_a: assert property ($rose(hv_reg) && mass_reg && erase_reg
        |-> $past(prot_val) == PROT_NONE)
        else $error("whole-array erase started while protected");
    prot_block_a: assert property ($rose(hv_reg) |-> !$past(lat_protected))
        else $error("high voltage raised on protected region");
    page_sweep_a: assert property ($rose(sweep_reg) && !mass_reg
        |-> sidx_reg[5:0] == 6'h00 && sleft_reg == PAGE_LAST)
        else $error("page sweep misaligned or wrong length");
    sweep_fill_a: assert property (sweep_reg |=> mem[$past(sidx_reg)] == ERASED_BYTE)
        else $error("swept byte not erased");
    sweep_hv_a: assert property (sweep_reg |-> hv_reg && erase_reg)
        else $error("sweep running without high voltage");
    ctrl_read_a: assert property (rd_i && is_ctrl |=>
        rdata_o == {CTRL_PAD, $past(hv_reg), $past(mass_reg), $past(erase_reg), $past(pgm_reg)})
        else $error("control read data wrong");
    rdata_idle_a: assert property (!rd_i |=> rdata_o == RDATA_IDLE)
        else $error("read data not idle after no read");
    prog_clear_a: assert property (prog_wr |=>
        mem[$past(idx)] == ($past(cell_val) & $past(wdata_i)))
        else $error("programmed byte wrong");

    // control register and interlock
    hv_refused_a: assert property (
        wr_i && is_ctrl && wdata_i[HV_BIT] && !hv_reg && !hv_allowed |=> !hv_reg)
        else $error("high voltage rose although refused");
    pump_drop_a: assert property (
        wr_i && is_ctrl && !wdata_i[HV_BIT] |=> !hv_reg)
        else $error("high voltage not dropped by a control write");
    hv_hold_a: assert property (hv_reg && !(wr_i && is_ctrl) |=> hv_reg)
        else $error("high voltage dropped without a control write");
    mass_write_a: assert property (
        wr_i && is_ctrl && wdata_i[MASS_BIT] |=> mass_reg)
        else $error("whole-array select not written");
    erase_write_a: assert property (
        wr_i && is_ctrl && !wdata_i[ERASE_BIT] |=> !erase_reg)
        else $error("erase select not cleared by a write");
    both_refused_a: assert property (
        wr_i && is_ctrl && wdata_i[ERASE_BIT] && wdata_i[PGM_BIT]
        |=> $stable(erase_reg) && $stable(pgm_reg))
        else $error("write with both selects changed them");

    // arming, protection, sweep and unmapped reads
    arm_write_a: assert property (
        (arm_reg == ARM_PROT) ##1 (arm_reg == ARM_ARMED) |-> $past(wr_i) && $past(is_array))
        else $error("arming step taken without an array write");
    arm_idle_a: assert property (
        !erase_reg && !pgm_reg && !hv_reg |=> arm_reg == ARM_IDLE)
        else $error("sequencer not restarted with selects clear");
    prot_write_a: assert property (
        wr_i && is_array && addr_protected && !sweep_reg
        |=> mem[$past(idx)] == $past(cell_val))
        else $error("protected byte changed by a write");
    lat_page_a: assert property (
        $rose(sweep_reg) && !mass_reg |-> sidx_reg[12:PAGE_AW] == lat_reg[12:PAGE_AW])
        else $error("page sweep not in the latched page");
    mass_sweep_a: assert property (
        $rose(sweep_reg) && mass_reg |-> sidx_reg == SWEEP_ZERO && sleft_reg == MASS_LAST)
        else $error("whole-array sweep misplaced or wrong length");
    sweep_step_a: assert property (
        sweep_reg && sleft_reg != SWEEP_ZERO && hv_next
        |=> sweep_reg && sidx_reg == $past(sidx_reg) + SWEEP_ONE)
        else $error("sweep skipped or stopped early");
    sweep_end_a: assert property (
        sweep_reg && sleft_reg == SWEEP_ZERO |=> !sweep_reg)
        else $error("sweep ran past its last byte");
    unmapped_read_a: assert property (
        rd_i && !is_ctrl && !is_array |=> rdata_o == RDATA_IDLE)
        else $error("unmapped read returned data");

    page_erase_c: cover property ($rose(sweep_reg) && !mass_reg);
    mass_erase_c: cover property ($rose(sweep_reg) && mass_reg);
    program_c:    cover property (prog_wr);
    refused_hv_c: cover property (wr_i && is_ctrl && wdata_i[HV_BIT] && !hv_reg
                                  && (arm_reg == ARM_ARMED) && !hv_allowed);

endmodule : fec_flash_ctrl

// [fec_pkg.sv]
// constants, register map and state type for the flash erase control block
package fec_pkg;

    // ----------------------------------------------------------------
    // bus and array geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned ARRAY_AW    = 13;             // 8192 words
    localparam int unsigned ARRAY_WORDS = 8192;
    localparam int unsigned PAGE_AW     = 6;              // 64-byte page

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam logic [15:0] CTRL_ADDR   = 16'hFE08;       // flash_control
    localparam logic [15:0] PROT_ADDR   = 16'hFF7E;       // flash_protect_start
    localparam logic [15:0] VECT_BASE   = 16'hFFDC;       // vectors up to 16'hFFFF
    localparam logic [2:0]  ARRAY_TOP   = 3'h7;           // addr[15:13] of the array
    localparam logic [12:0] PROT_IDX    = 13'h1F7E;       // protect byte inside array

    // ----------------------------------------------------------------
    // flash_control fields and reset value
    // ----------------------------------------------------------------
    localparam int unsigned HV_BIT      = 3;              // high_voltage_enable
    localparam int unsigned MASS_BIT    = 2;              // whole-array select
    localparam int unsigned ERASE_BIT   = 1;              // erase select
    localparam int unsigned PGM_BIT     = 0;              // program_select
    localparam logic [3:0]  CTRL_PAD    = 4'h0;           // unused bits read zero
    localparam logic [7:0]  CTRL_RESET  = 8'h00;

    // ----------------------------------------------------------------
    // data values and sweep counts
    // ----------------------------------------------------------------
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [7:0]  PROT_NONE   = 8'hFF;
    localparam logic [7:0]  RDATA_IDLE  = 8'h00;
    localparam logic [1:0]  PROT_HI     = 2'h3;           // start address bits 15:14
    localparam logic [5:0]  PROT_LO     = 6'h00;          // start address bits 5:0
    localparam logic [12:0] PAGE_LAST   = 13'h003F;       // 64 bytes minus one
    localparam logic [12:0] MASS_LAST   = 13'h1FFF;       // 8192 bytes minus one
    localparam logic [12:0] SWEEP_ZERO  = 13'h0000;
    localparam logic [12:0] SWEEP_ONE   = 13'h0001;

    // ----------------------------------------------------------------
    // arming sequence states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ARM_IDLE   = 5'b00001,
        ARM_SEL    = 5'b00010,
        ARM_PROT   = 5'b00100,
        ARM_ARMED  = 5'b01000,
        ARM_HIGH   = 5'b10000
    } fec_arm_e;

endpackage : fec_pkg

// [tb_top.sv]
// self-checking testbench for the flash erase control block
`timescale 1ns/1ns
module tb_top;
    import fec_pkg::*;

    // ----------------------------------------------------------------
    // signals and design instance
    // ----------------------------------------------------------------
    logic              clk_i;
    logic              rst_n_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic [DATA_W-1:0] rdata_o;
    logic              charge_pump_on_o;
    logic              erase_busy_o;
    int                fail_count;
    int                n_checks;
    logic [7:0]        rv;
    logic [7:0]        prot_exp;

    // control writes in a row and the control value read back after each
    localparam logic [7:0] ROWS [9][2] = '{'{8'h08, 8'h00}, '{8'h04, 8'h04},
        '{8'h03, 8'h00}, '{8'h02, 8'h02}, '{8'h0A, 8'h02}, '{8'h03, 8'h02},
        '{8'h01, 8'h01}, '{8'hF0, 8'h00}, '{8'h00, 8'h00}};

    fec_flash_ctrl uut (
        .clk_i            (clk_i),
        .rst_n_i          (rst_n_i),
        .addr_i           (addr_i),
        .wdata_i          (wdata_i),
        .wr_i             (wr_i),
        .rd_i             (rd_i),
        .rdata_o          (rdata_o),
        .charge_pump_on_o (charge_pump_on_o),
        .erase_busy_o     (erase_busy_o)
    );

    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    // one mismatch line per failing compare, four-state equality
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : chk

    // strobe dropped at the taking edge, so a gap cycle follows every access
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask : bus_wr

    task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        rv = rdata_o;
        chk(name, {8'h00, e}, {8'h00, rv});
    endtask : rd_chk

    // arm, raise voltage, time the sweep, then drop selects and voltage;
    // the long analogue waits are not modelled by the hardware and are cut
    task automatic erase(input logic [7:0] sel, input logic [15:0] a, input bit ok,
                         input int n);
        int k;
        bus_wr(CTRL_ADDR, sel);
        rd_chk("prot", PROT_ADDR, prot_exp);
        bus_wr(a, 8'h5A);
        bus_wr(CTRL_ADDR, sel | 8'h08);
        chk("pump", {15'h0, ok}, {15'h0, charge_pump_on_o});
        k = 0;
        while (erase_busy_o === 1'b1 && k < 9000) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk("sweep", ok ? n[15:0] : 16'h0000, k[15:0]);
        rd_chk("ctrl", CTRL_ADDR, ok ? (sel | 8'h08) : sel);
        bus_wr(CTRL_ADDR, 8'h08);
        bus_wr(CTRL_ADDR, 8'h00);
        chk("pump off", 16'h0000, {15'h0, charge_pump_on_o});
    endtask : erase

    task automatic program_byte(input logic [15:0] a, input logic [7:0] d);
        bus_wr(CTRL_ADDR, 8'h01);
        rd_chk("prot", PROT_ADDR, prot_exp);
        bus_wr(a, 8'hFF);
        bus_wr(CTRL_ADDR, 8'h09);
        bus_wr(a, d);
        bus_wr(CTRL_ADDR, 8'h08);
        bus_wr(CTRL_ADDR, 8'h00);
    endtask : program_byte

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------------------------------
    // watchdog, about six times the expected run
    // ----------------------------------------------------------------
    initial begin
        #500000;
        fail_count++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        fail_count = 0;
        n_checks   = 0;
        prot_exp   = PROT_NONE;
        rst_n_i    = 1'b0;
        addr_i     = 16'h0000;
        wdata_i    = 8'h00;
        wr_i       = 1'b0;
        rd_i       = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("rst outs", 16'h0000, {13'h0, rdata_o === 8'h00 ? 1'b0 : 1'b1,
            charge_pump_on_o, erase_busy_o});
        rd_chk("ctrl rst", CTRL_ADDR, CTRL_RESET);
        // control value table: interlock, refused voltage, unused bits
        for (int i = 0; i < 9; i++) begin
            bus_wr(CTRL_ADDR, ROWS[i][0]);
            rd_chk("ctrl row", CTRL_ADDR, ROWS[i][1]);
        end
        // unmapped space reads zero and read data stand a single cycle
        bus_wr(16'h1234, 8'h77);
        rd_chk("unmapped", 16'h1234, RDATA_IDLE);
        bus_wr(CTRL_ADDR, 8'h04);
        rd_chk("ctrl", CTRL_ADDR, 8'h04);
        @(posedge clk_i);
        #1;
        chk("rdata idle", {8'h00, RDATA_IDLE}, {8'h00, rdata_o});
        bus_wr(CTRL_ADDR, 8'h00);
        // page FF40 holds the protect byte; clean it, then the whole array
        erase(8'h02, 16'hFF55, 1'b1, 64);
        rd_chk("prot erased", PROT_ADDR, ERASED_BYTE);
        erase(8'h06, 16'hE000, 1'b1, 8192);
        rd_chk("lo", 16'hE000, ERASED_BYTE);
        rd_chk("mid", 16'hFDFF, ERASED_BYTE);
        rd_chk("top", 16'hFFFF, ERASED_BYTE);
        // programming only clears bits
        program_byte(16'hE000, 8'hA5);
        rd_chk("prog", 16'hE000, 8'hA5);
        program_byte(16'hE000, 8'hF0);
        rd_chk("prog and", 16'hE000, 8'hA0);
        program_byte(16'hE03F, 8'h00);
        program_byte(16'hE040, 8'h00);
        // protect from FF80 upward: start = {11, FE, 000000}
        program_byte(PROT_ADDR, 8'hFE);
        prot_exp = 8'hFE;
        rd_chk("prot set", PROT_ADDR, 8'hFE);
        erase(8'h06, 16'hE000, 1'b0, 0);
        erase(8'h02, 16'hFFC5, 1'b0, 0);
        program_byte(16'hFF80, 8'h00);
        rd_chk("prot edge", 16'hFF80, ERASED_BYTE);
        program_byte(16'hFF7F, 8'h00);
        rd_chk("below prot", 16'hFF7F, 8'h00);
        // page erase stops exactly at the 64-byte boundary
        erase(8'h02, 16'hE055, 1'b1, 64);
        rd_chk("prev page", 16'hE03F, 8'h00);
        rd_chk("page base", 16'hE040, ERASED_BYTE);
        rd_chk("page end", 16'hE07F, ERASED_BYTE);
        // reset in mid-sweep clears pump, sweep and sequencer at once
        bus_wr(CTRL_ADDR, 8'h02);
        rd_chk("prot", PROT_ADDR, prot_exp);
        bus_wr(16'hE0C0, 8'h00);
        bus_wr(CTRL_ADDR, 8'h0A);
        chk("busy", 16'h0001, {15'h0, erase_busy_o});
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("rst again", 16'h0000, {14'h0, charge_pump_on_o, erase_busy_o});
        rd_chk("ctrl again", CTRL_ADDR, CTRL_RESET);
        // without a fresh arming sequence the pump must stay off
        bus_wr(CTRL_ADDR, 8'h0A);
        rd_chk("no arm", CTRL_ADDR, 8'h02);
        bus_wr(CTRL_ADDR, 8'h00);
        print_verdict();
    end

endmodule : tb_top
